// ---- hbi_arb_if.sv ----
`timescale 1ns/1ps
interface hbi_arb_if;
   logic host_req;     // Host access pending
   logic host_gnt;     // Host slot granted, one cycle
   logic fetch_req;    // Display fetch pending
   logic fetch_gnt;    // Fetch slot granted, one cycle
   logic refresh_req;  // Refresh pending
   logic refresh_gnt;  // Refresh slot granted, one cycle

   // Requesting side
   modport host (output host_req, fetch_req, refresh_req,
                 input  host_gnt, fetch_gnt, refresh_gnt);
   // Arbiter side
   modport arb  (input  host_req, fetch_req, refresh_req,
                 output host_gnt, fetch_gnt, refresh_gnt);
endinterface : hbi_arb_if

// ---- hbi_checker_asserts.sv ----
`timescale 1ns/1ps
module hbi_checker
   import hbi_pkg::*;
(
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        nrst,
   // Host pins
   input wire logic        hb_io_rd_n,
   input wire logic        hb_io_wr_n,
   input wire logic        hb_mem_rd_n,
   input wire logic        hb_mem_wr_n,
   input wire logic        hb_rom_sel_n,
   input wire logic [15:0] hb_rdata,
   input wire logic        hb_data_oe,
   input wire logic        hb_ready,
   input wire logic        hb_mem16,
   // Memory and sequencer
   input wire logic        mode_planar,
   input wire logic        mem_go,
   input wire logic        mem_wide,
   input wire logic        mem_done,
   input wire logic        refresh_req,
   input wire logic        fetch_gnt,
   input wire logic        refresh_gnt,
   // Configuration
   input wire logic [7:0]  powerup_config_word,
   input wire logic        bus_isa
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   a_io_no_wait: assert property ((!hb_io_rd_n || !hb_io_wr_n) && hb_mem_rd_n && hb_mem_wr_n |-> hb_ready)
      else $error("wait state on io cycle");
   a_rom_no_wait: assert property (!hb_rom_sel_n |-> hb_ready && !hb_data_oe)
      else $error("wait or data on rom cycle");
   a_mem_wait: assert property (($fell(hb_mem_rd_n) || $fell(hb_mem_wr_n)) && hb_rom_sel_n |-> ##[2:8] !hb_ready)
      else $error("no wait state on memory cycle");
   a_ready_done: assert property ($rose(hb_ready) |-> $past(mem_done))
      else $error("ready without memory done");
   a_go_in_wait: assert property (mem_go |-> !hb_ready)
      else $error("memory start outside host cycle");
   a_go_pulse: assert property (mem_go |=> !mem_go)
      else $error("memory start longer than one cycle");
   a_planar_byte: assert property (mem_go && mode_planar |-> !mem_wide)
      else $error("word transfer in planar mode");
   a_wide_path: assert property (mem_go && mem_wide |-> hb_mem16)
      else $error("word transfer not allowed");
   a_io_byte: assert property (hb_data_oe && !hb_io_rd_n |-> hb_rdata[15:8] == hb_rdata[7:0])
      else $error("io read not one byte");
   a_slot_gap: assert property (fetch_gnt || refresh_gnt |=> (!fetch_gnt && !refresh_gnt) [*3])
      else $error("two grants in one slot");
   a_refresh_first: assert property (fetch_gnt |-> !$past(refresh_req))
      else $error("fetch granted over refresh");
   a_bus_sel: assert property (bus_isa == (powerup_config_word[CFG_BUS_BIT] == ISA_MODE_LEVEL))
      else $error("bus type not from config bit");
endmodule : hbi_checker

bind vga_host_bus_interface hbi_checker hbi_checker_inst (.*);

// ---- hbi_pkg.sv ----
package hbi_pkg;

   // Power-up configuration word layout
   localparam int          CFG_W          = 8;
   localparam int          CFG_BUS_BIT    = 2;       // Bus type select bit
   localparam int          CFG_PATH16_BIT = 3;       // 16-bit host data path bit
   localparam logic        ISA_MODE_LEVEL = 1'b0;    // Bus bit level meaning ISA-style
   localparam logic [7:0]  CFG_RST        = 8'h00;

   // Internally decoded I/O ports, the setup port on the ISA-style bus only
   localparam logic [15:0] SETUP_PORT_ADDR  = 16'h46E8;
   localparam logic [15:0] ENABLE_PORT_ADDR = 16'h0102;
   localparam int          ENABLE_BIT       = 0;
   localparam logic [7:0]  SETUP_RST        = 8'h00;
   localparam logic [7:0]  ENABLE_RST       = 8'h01;

   // Cycles from reset release until the synchronised lines are valid
   localparam logic [1:0]  CAPTURE_DELAY = 2'h3;

   // Sequencer slot period in clk_sys cycles
   localparam int          SLOT_CYCLES = 4;

   // Host pin bundle, sampled through the synchroniser
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [7:0]  straps;
      logic        io_rd_n;
      logic        io_wr_n;
      logic        mem_rd_n;
      logic        mem_wr_n;
      logic        rom_n;
      logic        bhe_n;
   } pins_s;

   localparam pins_s PINS_RST = '{addr: 16'h0000, wdata: 16'h0000, straps: 8'h00,
                                 io_rd_n: 1'b1, io_wr_n: 1'b1, mem_rd_n: 1'b1,
                                 mem_wr_n: 1'b1, rom_n: 1'b1, bhe_n: 1'b1};

   // Host cycle states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_IO    = 3'b001,
      ST_MREQ  = 3'b010,
      ST_MBUSY = 3'b011,
      ST_HOLD  = 3'b100
   } hst_e;

endpackage : hbi_pkg

// ---- host_bus_model.sv ----
`timescale 1ns/1ps
module host_bus_model
   import hbi_pkg::*;
(
   // Clock
   input  wire logic        clk_sys,
   // Device answer
   input  wire logic [15:0] hb_rdata,
   input  wire logic        hb_ready,
   // Host lines
   output logic      [15:0] hb_addr,
   output logic      [15:0] hb_wdata,
   output logic             hb_io_rd_n,
   output logic             hb_io_wr_n,
   output logic             hb_mem_rd_n,
   output logic             hb_mem_wr_n,
   output logic             hb_rom_sel_n,
   output logic             hb_bhe_n
);
   // Idle bus at time zero
   initial begin
      {hb_addr, hb_wdata} = '0;
      {hb_io_rd_n, hb_io_wr_n, hb_mem_rd_n, hb_mem_wr_n, hb_rom_sel_n, hb_bhe_n} = 6'h3F;
   end

   // One host cycle: k[0] write, k[1] memory, k[2] rom
   task automatic cycle(input logic [2:0] k, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] rd);
      int n;
      @(posedge clk_sys);
      hb_addr      <= a;
      hb_wdata     <= d;
      hb_bhe_n     <= 1'b0;
      hb_io_rd_n   <= k[1:0] != 2'h0;
      hb_io_wr_n   <= k[1:0] != 2'h1;
      hb_mem_rd_n  <= k[1:0] != 2'h2;
      hb_mem_wr_n  <= k[1:0] != 2'h3;
      hb_rom_sel_n <= !k[2];
      repeat (10) @(posedge clk_sys);
      // Extend the cycle while the device asks for waits
      for (n = 0; n < 200 && hb_ready !== 1'b1; n++) @(posedge clk_sys);
      rd = hb_rdata;
      // Released address and data lines show the inverse of their last value, strobes go idle high
      hb_addr  <= ~a;
      hb_wdata <= ~d;
      {hb_io_rd_n, hb_io_wr_n, hb_mem_rd_n, hb_mem_wr_n, hb_rom_sel_n, hb_bhe_n} <= 6'h3F;
      repeat (8) @(posedge clk_sys);
   endtask : cycle
endmodule : host_bus_model

// ---- slot_arbiter.sv ----
`timescale 1ns/1ps
module slot_arbiter
   import hbi_pkg::*;
#(
   parameter int SLOTS = SLOT_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Requests and grants
   hbi_arb_if.arb   arb
);

   localparam int CW = $clog2(SLOTS) + 1;
   localparam logic [CW-1:0] LAST = CW'(SLOTS - 1);

   // Whole arbiter state
   typedef struct packed {
      logic [CW-1:0] div;
      logic          host_gnt;
      logic          fetch_gnt;
      logic          refresh_gnt;
   } arb_s;

   arb_s q;  // Registered state
   arb_s d;  // Next state

   // Slot divider and fixed priority: refresh, fetch, then host
   always_comb begin
      d             = q;
      d.host_gnt    = 1'b0;
      d.fetch_gnt   = 1'b0;
      d.refresh_gnt = 1'b0;
      if (q.div == LAST) begin
         d.div = '0;
         if (arb.refresh_req) begin  // Refresh against host
            d.refresh_gnt = 1'b1;
         end else if (arb.fetch_req) begin  // Fetch against host
            d.fetch_gnt = 1'b1;
         end else if (arb.host_req) begin
            d.host_gnt = 1'b1;
         end
      end else begin
         d.div = q.div + 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign arb.host_gnt    = q.host_gnt;
   assign arb.fetch_gnt   = q.fetch_gnt;
   assign arb.refresh_gnt = q.refresh_gnt;

endmodule : slot_arbiter

// ---- vga_host_bus_interface.sv ----
`timescale 1ns/1ps
module vga_host_bus_interface
   import hbi_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   // Host bus pins
   input  wire logic [15:0] hb_addr,
   input  wire logic [15:0] hb_wdata,
   input  wire logic        hb_io_rd_n,
   input  wire logic        hb_io_wr_n,
   input  wire logic        hb_mem_rd_n,
   input  wire logic        hb_mem_wr_n,
   input  wire logic        hb_rom_sel_n,
   input  wire logic        hb_bhe_n,
   output logic      [15:0] hb_rdata,
   output logic             hb_data_oe,
   output logic             hb_ready,
   output logic             hb_mem16,
   // Strap pins
   input  wire logic [7:0]  memory_data_lines,
   // Video mode from the register file
   input  wire logic        mode_planar,
   input  wire logic        mode_text,
   input  wire logic        mode_ext256,
   // Internal register access
   output logic             io_req,
   output logic             io_we,
   output logic      [15:0] io_addr,
   output logic      [7:0]  io_wdata,
   input  wire logic [7:0]  io_rdata,
   // Display memory access
   output logic             mem_go,
   output logic             mem_we,
   output logic             mem_wide,
   output logic      [15:0] mem_addr,
   output logic      [15:0] mem_wdata,
   input  wire logic        mem_done,
   input  wire logic [15:0] mem_rdata,
   // Sequencer requests
   input  wire logic        fetch_req,
   input  wire logic        refresh_req,
   output logic             fetch_gnt,
   output logic             refresh_gnt,
   // Configuration and port state
   output logic      [7:0]  powerup_config_word,
   output logic             bus_isa,
   output logic      [7:0]  setup_reg,
   output logic             video_enable
);

   // Whole block state
   typedef struct packed {
      pins_s       s1;        // First synchroniser stage
      pins_s       s2;        // Second stage
      pins_s       s3;        // Third stage
      pins_s       stb;       // Debounced pin view
      logic [1:0]  cap_cnt;   // Cycles since reset release
      logic        cap_done;  // Config word valid
      logic [7:0]  cfg;       // Power-up configuration word
      logic        bus_isa;   // Registered bus type
      hst_e        st;        // Host cycle state
      logic        host_req;  // Slot request to sequencer
      logic        wr;        // Current cycle is a write
      logic        wide;      // Current memory cycle is a word
      logic        odd;       // Byte sits on the high lane
      logic [15:0] rdata;
      logic        oe;
      logic        ready;
      logic        mem16;
      logic        io_req;
      logic        io_we;
      logic [15:0] io_addr;
      logic [7:0]  io_wdata;
      logic        mem_go;
      logic [15:0] mem_addr;
      logic [15:0] mem_wdata;
      logic [7:0]  setup;     // Setup port contents
      logic [7:0]  enable;    // Enable port contents
   } hbi_s;

   hbi_s q;  // Registered state
   hbi_s d;  // Next state

   pins_s pin_now;  // Raw pin bundle
   pins_s flip;     // Bits where stages two and three differ
   logic  isa;      // ISA-style bus selected
   logic  path16;   // 16-bit host data path
   logic  io_act;   // Stable I/O strobe
   logic  mem_act;  // Stable memory strobe
   logic  any_act;  // Any strobe still active
   logic  io_rd;    // Stable I/O read
   logic  mem_rd;   // Stable memory read
   logic  is_setup; // Setup port hit
   logic  is_enab;  // Enable port hit
   logic  word_ok;  // Mode and path allow word transfers
   logic  hi_lane;  // Odd byte on 16-bit path
   logic  [7:0] wbyte; // Write byte from the correct lane

   // Sequencer handshake
   hbi_arb_if arb_if ();

   slot_arbiter #(
      .SLOTS (SLOT_CYCLES)
   ) slot_arbiter_inst (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .arb     (arb_if.arb)
   );

   assign arb_if.host_req    = q.host_req;
   assign arb_if.fetch_req   = fetch_req;
   assign arb_if.refresh_req = refresh_req;

   // Pin bundle and decodes from the debounced view
   always_comb begin
      pin_now  = '{addr: hb_addr, wdata: hb_wdata, straps: memory_data_lines,
                   io_rd_n: hb_io_rd_n, io_wr_n: hb_io_wr_n,
                   mem_rd_n: hb_mem_rd_n, mem_wr_n: hb_mem_wr_n,
                   rom_n: hb_rom_sel_n, bhe_n: hb_bhe_n};
      flip     = q.s2 ^ q.s3;
      isa      = (q.cfg[CFG_BUS_BIT] == ISA_MODE_LEVEL);
      path16   = q.cfg[CFG_PATH16_BIT];
      io_rd    = !q.stb.io_rd_n;
      mem_rd   = !q.stb.mem_rd_n;
      io_act   = io_rd || !q.stb.io_wr_n;
      mem_act  = mem_rd || !q.stb.mem_wr_n;
      any_act  = io_act || mem_act;
      is_setup = isa && (q.stb.addr == SETUP_PORT_ADDR);
      is_enab  = (q.stb.addr == ENABLE_PORT_ADDR);
      // Word transfers only in text or 256-colour modes on a wide path
      word_ok  = path16 && !mode_planar && (mode_text || mode_ext256);
      hi_lane  = path16 && q.stb.addr[0];
      wbyte    = hi_lane ? q.stb.wdata[15:8] : q.stb.wdata[7:0];
   end

   // Next-state logic
   always_comb begin
      d        = q;
      d.s1     = pin_now;
      d.s2     = q.s1;
      d.s3     = q.s2;
      // A bit changes once stages two and three agree
      d.stb    = (q.s3 & ~flip) | (q.stb & flip);
      d.io_req = 1'b0;
      d.mem_go = 1'b0;
      d.mem16  = word_ok;

      // Config word caught once the synchroniser has refilled
      if (!q.cap_done) begin
         if (q.cap_cnt == CAPTURE_DELAY) begin
            d.cfg      = ~q.s3.straps;
            d.cap_done = 1'b1;
         end else begin
            d.cap_cnt = q.cap_cnt + 1'b1;
         end
      end
      // Bus type kept in its own flop so the pin comes from a register
      d.bus_isa = (d.cfg[CFG_BUS_BIT] == ISA_MODE_LEVEL);

      case (q.st)
         // Wait for a new strobe
         ST_IDLE: begin
            d.ready = 1'b1;
            d.oe    = 1'b0;
            if (!q.cap_done) begin
               d.st = ST_IDLE;
            end else if (io_act) begin
               // One byte per I/O cycle, no wait states
               d.wr      = !io_rd;
               d.odd     = hi_lane;
               d.io_addr = q.stb.addr;
               d.io_wdata = wbyte;
               d.io_we   = !io_rd;
               d.io_req  = !(is_setup || is_enab);
               d.st      = ST_IO;
            end else if (mem_act && !q.stb.rom_n) begin
               // ROM cycle completes with ready untouched
               d.st = ST_HOLD;
            end else if (mem_act) begin
               d.wr       = !mem_rd;
               d.wide     = word_ok && !q.stb.bhe_n && !q.stb.addr[0];
               d.odd      = hi_lane;
               d.mem_addr = q.stb.addr;
               d.mem_wdata = (word_ok && !q.stb.bhe_n && !q.stb.addr[0]) ?
                             q.stb.wdata : {8'h00, wbyte};
               d.ready    = 1'b0;
               d.host_req = 1'b1;
               d.st       = ST_MREQ;
            end
         end
         // Finish an I/O cycle
         ST_IO: begin
            if (q.wr) begin
               if (is_setup) begin
                  d.setup = q.io_wdata;
               end
               if (is_enab) begin
                  d.enable = q.io_wdata;
               end
            end else begin
               // Read byte placed on both lanes
               if (is_setup) begin
                  d.rdata = {q.setup, q.setup};
               end else if (is_enab) begin
                  d.rdata = {q.enable, q.enable};
               end else begin
                  d.rdata = {io_rdata, io_rdata};
               end
               d.oe = 1'b1;
            end
            d.st = ST_HOLD;
         end
         // Waiting for a sequencer slot
         ST_MREQ: begin
            d.ready = 1'b0;
            if (arb_if.host_gnt) begin
               d.host_req = 1'b0;
               d.mem_go   = 1'b1;
               d.st       = ST_MBUSY;
            end
         end
         // Memory access in flight
         ST_MBUSY: begin
            d.ready = 1'b0;
            if (mem_done) begin
               if (!q.wr) begin
                  if (q.wide) begin
                     d.rdata = mem_rdata;
                  end else begin
                     d.rdata = {mem_rdata[7:0], mem_rdata[7:0]};
                  end
                  d.oe = 1'b1;
               end
               d.ready = 1'b1;
               d.st    = ST_HOLD;
            end
         end
         // Host ends the cycle by releasing its strobe
         ST_HOLD: begin
            d.ready = 1'b1;
            if (!any_act) begin
               d.oe = 1'b0;
               d.st = ST_IDLE;
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         q          <= '0;
         q.s1       <= PINS_RST;
         q.s2       <= PINS_RST;
         q.s3       <= PINS_RST;
         q.stb      <= PINS_RST;
         q.cfg      <= CFG_RST;
         q.bus_isa  <= (CFG_RST[CFG_BUS_BIT] == ISA_MODE_LEVEL);
         q.st       <= ST_IDLE;
         q.ready    <= 1'b1;
         q.setup    <= SETUP_RST;
         q.enable   <= ENABLE_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from flip-flops
   assign hb_rdata            = q.rdata;
   assign hb_data_oe          = q.oe;
   assign hb_ready            = q.ready;
   assign hb_mem16            = q.mem16;
   assign io_req              = q.io_req;
   assign io_we               = q.io_we;
   assign io_addr             = q.io_addr;
   assign io_wdata            = q.io_wdata;
   assign mem_go              = q.mem_go;
   assign mem_we              = q.wr;
   assign mem_wide            = q.wide;
   assign mem_addr            = q.mem_addr;
   assign mem_wdata           = q.mem_wdata;
   assign fetch_gnt           = arb_if.fetch_gnt;
   assign refresh_gnt         = arb_if.refresh_gnt;
   assign powerup_config_word = q.cfg;
   assign bus_isa             = q.bus_isa;
   assign setup_reg           = q.setup;
   assign video_enable        = q.enable[ENABLE_BIT];

endmodule : vga_host_bus_interface

// ---- vga_host_bus_interface_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %s exp %h seen %h", nm, e, g); end end
module vga_host_bus_interface_tb
   import hbi_pkg::*;
;
   // Design and model signals
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic [15:0] hb_addr, hb_wdata, hb_rdata, io_addr, mem_addr, mem_wdata, rd, go_addr, go_wdata, io_a;
   logic [15:0] mem_rdata = 16'h0000;
   logic        hb_io_rd_n, hb_io_wr_n, hb_mem_rd_n, hb_mem_wr_n, hb_rom_sel_n, hb_bhe_n;
   logic        hb_data_oe, hb_ready, hb_mem16, io_req, io_we, mem_go, mem_we, mem_wide;
   logic        fetch_gnt, refresh_gnt, bus_isa, video_enable, go_wide, go_we, io_w;
   logic        mem_done = 1'b0;
   logic        mode_planar = 1'b0, mode_text = 1'b1, mode_ext256 = 1'b0;
   logic        fetch_req = 1'b0, refresh_req = 1'b0;
   logic [7:0]  io_wdata, powerup_config_word, setup_reg, io_d;
   logic [7:0]  memory_data_lines = 8'h34;
   wire  [7:0]  io_rdata = io_req ? 8'h69 : 8'h96;  // Register answer while io_req stands
   logic [1:0]  mcnt = 2'h0;
   int          n_fail = 0, checked = 0, cyc = 0, n_io = 0, n_go = 0, n_fg = 0, n_rg = 0, n_oe = 0;

   always #2.5 clk_sys = ~clk_sys;

   vga_host_bus_interface vga_host_bus_interface_inst (.*);
   host_bus_model host_bus_model_inst (.*);

   // Register and memory responders, transfer monitor, timeout
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (io_req) begin
         n_io <= n_io + 1;
         {io_a, io_d, io_w} <= {io_addr, io_wdata, io_we};
      end
      if (mem_go) begin
         n_go <= n_go + 1;
         {go_addr, go_wdata, go_wide, go_we} <= {mem_addr, mem_wdata, mem_wide, mem_we};
      end
      n_fg <= n_fg + int'(fetch_gnt);
      n_rg <= n_rg + int'(refresh_gnt);
      n_oe <= n_oe + int'(hb_data_oe);
      mcnt <= mem_go ? 2'h3 : (mcnt != 2'h0 ? mcnt - 2'h1 : 2'h0);
      mem_done <= mcnt == 2'h1;
      mem_rdata <= (mcnt == 2'h1) ? 16'h5A3C : 16'hA5C3;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test

   // Reset with given straps, then check capture
   task automatic do_reset(input logic [7:0] straps);
      nrst <= 1'b0;
      memory_data_lines <= straps;
      repeat (5) @(posedge clk_sys);
      `CHK("enable_rst", ENABLE_RST[ENABLE_BIT], video_enable)
      `CHK("setup_rst", SETUP_RST, setup_reg)
      nrst <= 1'b1;
      repeat (12) @(posedge clk_sys);
      `CHK("config", ~straps, powerup_config_word)
      `CHK("bus_isa", ~straps[CFG_BUS_BIT] == ISA_MODE_LEVEL, bus_isa)
   endtask : do_reset

   // Setup and enable ports on the ISA-style bus
   task automatic t_ports();
      int n0;
      n0 = n_io;
      host_bus_model_inst.cycle(3'h1, SETUP_PORT_ADDR, 16'hA5A5, rd);
      `CHK("setup_wr", 8'hA5, setup_reg)
      host_bus_model_inst.cycle(3'h0, SETUP_PORT_ADDR, 16'h0000, rd);
      `CHK("setup_rd", 16'hA5A5, rd)
      host_bus_model_inst.cycle(3'h1, ENABLE_PORT_ADDR, 16'h0000, rd);
      `CHK("vid_off", 1'b0, video_enable)
      host_bus_model_inst.cycle(3'h1, ENABLE_PORT_ADDR, 16'h0101, rd);
      `CHK("vid_on", 1'b1, video_enable)
      `CHK("no_io_req", n0, n_io)
      host_bus_model_inst.cycle(3'h1, 16'h03C4, 16'h3C3C, rd);
      `CHK("io_cnt", n0 + 1, n_io)
      `CHK("io_addr", 16'h03C4, io_a)
      `CHK("io_data", 8'h3C, io_d)
      `CHK("io_we", 1'b1, io_w)
      n0 = n_oe;
      host_bus_model_inst.cycle(3'h0, 16'h03C5, 16'h0000, rd);
      `CHK("io_rd", 16'h6969, rd)
      `CHK("io_rd_oe", 1'b1, n_oe > n0)
   endtask : t_ports

   // Memory widths by mode, waits, rom cycle
   task automatic t_mem();
      int n0, n1;
      repeat (3) @(posedge clk_sys);
      `CHK("mem16_text", 1'b1, hb_mem16)
      host_bus_model_inst.cycle(3'h2, 16'h0100, 16'h0000, rd);
      `CHK("mrd_data", 16'h5A3C, rd)
      `CHK("mrd_wide", 1'b1, go_wide)
      `CHK("mrd_addr", 16'h0100, go_addr)
      mode_text <= 1'b0;
      mode_ext256 <= 1'b1;
      repeat (3) @(posedge clk_sys);
      `CHK("mem16_256", 1'b1, hb_mem16)
      mode_ext256 <= 1'b0;
      mode_planar <= 1'b1;
      repeat (3) @(posedge clk_sys);
      `CHK("mem16_planar", 1'b0, hb_mem16)
      host_bus_model_inst.cycle(3'h3, 16'h0101, 16'hC300, rd);
      `CHK("mwr_wide", 1'b0, go_wide)
      `CHK("mwr_byte", 8'hC3, go_wdata[7:0])
      `CHK("mwr_we", 1'b1, go_we)
      n0 = n_go;
      n1 = n_oe;
      host_bus_model_inst.cycle(3'h6, 16'h0200, 16'h0000, rd);
      `CHK("rom_no_go", n0, n_go)
      `CHK("rom_no_oe", n1, n_oe)
      mode_planar <= 1'b0;
      mode_text <= 1'b1;
   endtask : t_mem

   // Refresh over fetch, one grant per slot
   task automatic t_seq();
      int n0, n1;
      refresh_req <= 1'b1;
      fetch_req <= 1'b1;
      repeat (8) @(posedge clk_sys);
      n0 = n_rg;
      n1 = n_fg;
      repeat (40) @(posedge clk_sys);
      `CHK("rfsh_cnt", n0 + 40 / SLOT_CYCLES, n_rg)
      `CHK("fetch_held", n1, n_fg)
      refresh_req <= 1'b0;
      repeat (8) @(posedge clk_sys);
      n1 = n_fg;
      repeat (40) @(posedge clk_sys);
      `CHK("fetch_cnt", n1 + 40 / SLOT_CYCLES, n_fg)
      fetch_req <= 1'b0;
   endtask : t_seq

   // Alternate bus on an 8-bit path
   task automatic t_alt_bus();
      int n0;
      n0 = n_io;
      host_bus_model_inst.cycle(3'h1, SETUP_PORT_ADDR, 16'h5A5A, rd);
      `CHK("setup_hold", SETUP_RST, setup_reg)
      `CHK("setup_fwd", n0 + 1, n_io)
      `CHK("mem16_path8", 1'b0, hb_mem16)
      host_bus_model_inst.cycle(3'h2, 16'h0100, 16'h0000, rd);
      `CHK("mrd8_wide", 1'b0, go_wide)
   endtask : t_alt_bus

   // Main sequence
   initial begin
      do_reset(8'h34);
      t_ports();
      t_mem();
      t_seq();
      do_reset(8'h38);
      t_alt_bus();
      end_of_test();
   end
endmodule : vga_host_bus_interface_tb
